// >>> rtl/mhp_pkg.sv
// Constants shared by the master host port design
package mhp_pkg;
  // Local special-function-space offsets
  localparam logic [7:0] DATA0_OFS = 8'h48;
  localparam logic [7:0] STAT0_OFS = 8'h49;
  localparam logic [7:0] CTRL0_OFS = 8'h4a;
  localparam logic [7:0] DATA1_OFS = 8'h4c;
  localparam logic [7:0] STAT1_OFS = 8'h4d;
  localparam logic [7:0] CTRL1_OFS = 8'h4e;
  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;
  // Control field positions
  localparam int CTL_OBF_PIN = 0;
  localparam int CTL_IBF_PIN = 1;
  localparam int CTL_CMD_ONLY = 2;
  localparam int CTL_OBE_DIS = 3;
  localparam int CTL_IBF_DIS = 4;
  localparam int CTL_RSVD = 5;
  localparam int CTL_PORT_EN = 6;
  localparam int CTL_MODE7 = 7;
  // Status field positions
  localparam int ST_OBF = 0;
  localparam int ST_IBF = 1;
  localparam int ST_A0 = 3;
  // Mask of software-writable status bits (2,4,5,6,7)
  localparam logic [7:0] ST_SW_MASK = 8'hf4;
  // Master FIFO shape: buffer, A0 level and data byte per entry
  localparam int FIFO_W = 10;
  localparam int FIFO_D = 16;
  // Synchroniser length in cycles
  localparam int SYNC_STAGES = 2;
endpackage : mhp_pkg

// >>> rtl/mhp_fifo.sv
// Small valid/ready FIFO used in the master write path
`timescale 1ns/10ps
module mhp_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  // Storage array
  logic [W-1:0] mem [D];
  // Pointers and count held in one struct
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } mhp_fifo_st_t;
  mhp_fifo_st_t s_r, s_nxt;
  logic push, pop;

  // Honest full and empty
  assign in_ready = (s_r.cnt != (AW+1)'(D));
  assign out_valid = (s_r.cnt != '0);
  assign out_data = mem[s_r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer update
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Array write, no reset needed for data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_r.wp] <= in_data;
    end
  end
endmodule : mhp_fifo

// >>> rtl/mhp_host_port.sv
// Master host port: slave parallel port with two data buffer pairs
`timescale 1ns/10ps
module mhp_host_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Local special function space access
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Port control threshold bit from the port block
  input wire logic input_threshold_select,
  output logic ttl_level_en,
  // Master data lines
  input wire logic [7:0] host_data_lines_in,
  output logic [7:0] host_data_lines_out,
  output logic host_data_lines_oe,
  // Master control inputs
  input wire logic host_select_a_n,
  input wire logic host_select_b_n,
  input wire logic cmd_data_select,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  // Pin function selects towards port logic
  output logic port_function_enable,
  output logic dual_buffer_select,
  // Flag pins
  output logic out_buffer_full0,
  output logic in_buffer_full0_n,
  output logic out_buffer_full1,
  output logic in_buffer_full1_n,
  output logic obf0_pin_en,
  output logic ibf0_pin_en,
  output logic obf1_pin_en,
  output logic ibf1_pin_en,
  // Interrupt requests to local CPU, one-cycle pulses
  output logic ibf_irq0,
  output logic obe_irq0,
  output logic ibf_irq1,
  output logic obe_irq1,
  // Backlog indicator
  output logic wr_fifo_full
);
  // Synchronised control vector: sa, sb, a0, rd, wr
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [7:0] d1;
    logic [7:0] d2;
  } mhp_sync_t;

  // Module state apart from the synchronisers, reset pipeline and write FIFO
  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] in0;
    logic [7:0] in1;
    logic [7:0] out0;
    logic [7:0] out1;
    logic [7:0] dq_out;
    logic dq_oe;
    logic [3:0] irq;
  } mhp_state_t;

  mhp_sync_t y_r, y_nxt;
  mhp_state_t s_r, s_nxt;
  // Reset release pipeline; kept apart since the pin reset clears it
  logic [1:0] rst_sync_r;
  logic rst_n;
  // Decoded synchronised controls
  logic sel_a, sel_b, a0_s, rd_act, wr_act, rd_prev, wr_prev;
  logic rd_start, wr_end, strobe_style, dual;
  // Master write FIFO path: {buffer, a0, data} packed as 10 bits
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [mhp_pkg::FIFO_W-1:0] f_in_data, f_out_data;
  logic [7:0] wr_byte;
  logic wr_buf, wr_a0;

  // Reset release through two flip-flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Two-stage synchroniser on all master pins, third stage for edges
  always_comb begin
    y_nxt = y_r;
    y_nxt.s1 = {host_select_a_n, host_select_b_n, cmd_data_select,
                host_rd_n, host_wr_n};
    y_nxt.s2 = y_r.s1;
    y_nxt.s3 = y_r.s2;
    y_nxt.d1 = host_data_lines_in;
    y_nxt.d2 = y_r.d1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      y_r <= '{s1: 5'h1f, s2: 5'h1f, s3: 5'h1f, d1: 8'h00, d2: 8'h00};
    end else begin
      y_r <= y_nxt;
    end
  end

  assign strobe_style = s_r.ctl0[mhp_pkg::CTL_MODE7];
  assign dual = s_r.ctl1[mhp_pkg::CTL_MODE7];
  assign port_function_enable = s_r.ctl0[mhp_pkg::CTL_PORT_EN];
  assign dual_buffer_select = dual;
  assign ttl_level_en = input_threshold_select;

  // Decode strobes; R/W style uses rd pin as E, wr pin as R/W
  function automatic logic [1:0] strobes(input logic [4:0] v,
                                         input logic style);
    logic [1:0] r;
    r = 2'h0;
    if (style) begin
      r[1] = v[1] & v[0];
      r[0] = v[1] & ~v[0];
    end else begin
      r[1] = ~v[1];
      r[0] = ~v[0];
    end
    return r;
  endfunction : strobes

  // Current and previous strobe levels, select qualified
  always_comb begin
    sel_a = ~y_r.s2[4];
    sel_b = ~y_r.s2[3] & dual;
    a0_s = y_r.s2[2];
    {rd_act, wr_act} = strobes(y_r.s2, strobe_style);
    {rd_prev, wr_prev} = strobes(y_r.s3, strobe_style);
    rd_start = rd_act & ~rd_prev & (sel_a | sel_b)
               & port_function_enable;
    wr_end = ~wr_act & wr_prev & (~y_r.s3[4] | (~y_r.s3[3] & dual))
             & port_function_enable;
  end

  // Master writes queue here; data held stable by master through edge
  // A0 comes from the last cycle in which the strobe was seen active
  assign wr_buf = y_r.s3[4];
  assign wr_a0 = y_r.s3[2];
  assign wr_byte = y_r.d2;
  assign f_in_valid = wr_end;
  assign f_in_data = {wr_buf, wr_a0, wr_byte};
  assign wr_fifo_full = ~f_in_ready;

  mhp_fifo #(.W(mhp_pkg::FIFO_W), .D(mhp_pkg::FIFO_D)) u_wr_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // Drain stalls while target input buffer is still full
  // Entry bit 9 picks the buffer, bit 8 carries the A0 level
  assign f_out_ready = f_out_data[9]
                       ? ~s_r.st1[mhp_pkg::ST_IBF]
                       : ~s_r.st0[mhp_pkg::ST_IBF];

  // Register, flag and bus behaviour
  always_comb begin
    logic lwr0, lwr1, lrd0, lrd1, pop, a0q;
    s_nxt = s_r;
    s_nxt.irq = 4'h0;
    pop = f_out_valid & f_out_ready;
    a0q = a0_s;
    lwr0 = sfr_wr & (sfr_addr == mhp_pkg::DATA0_OFS);
    lwr1 = sfr_wr & (sfr_addr == mhp_pkg::DATA1_OFS);
    lrd0 = sfr_rd & (sfr_addr == mhp_pkg::DATA0_OFS);
    lrd1 = sfr_rd & (sfr_addr == mhp_pkg::DATA1_OFS);
    // Control writes, reserved bit forced to zero
    if (sfr_wr && sfr_addr == mhp_pkg::CTRL0_OFS) begin
      s_nxt.ctl0 = sfr_wdata;
      s_nxt.ctl0[mhp_pkg::CTL_RSVD] = 1'b0;
    end
    if (sfr_wr && sfr_addr == mhp_pkg::CTRL1_OFS) begin
      s_nxt.ctl1 = sfr_wdata & 8'h9f;
    end
    // Software status bits only
    if (sfr_wr && sfr_addr == mhp_pkg::STAT0_OFS) begin
      s_nxt.st0 = (s_r.st0 & ~mhp_pkg::ST_SW_MASK)
                  | (sfr_wdata & mhp_pkg::ST_SW_MASK);
    end
    if (sfr_wr && sfr_addr == mhp_pkg::STAT1_OFS) begin
      s_nxt.st1 = (s_r.st1 & ~mhp_pkg::ST_SW_MASK)
                  | (sfr_wdata & mhp_pkg::ST_SW_MASK);
    end
    // Local loads of output latches
    if (lwr0) begin
      s_nxt.out0 = sfr_wdata;
      s_nxt.st0[mhp_pkg::ST_OBF] = 1'b1;
    end
    if (lwr1) begin
      s_nxt.out1 = sfr_wdata;
      s_nxt.st1[mhp_pkg::ST_OBF] = 1'b1;
    end
    // Local reads clear input full
    if (lrd0) begin
      s_nxt.st0[mhp_pkg::ST_IBF] = 1'b0;
    end
    if (lrd1) begin
      s_nxt.st1[mhp_pkg::ST_IBF] = 1'b0;
    end
    // Master read: status on A0 high, data on A0 low
    if (rd_start) begin
      if (a0q) begin
        s_nxt.dq_out = sel_a ? s_r.st0 : s_r.st1;
      end else if (sel_a) begin
        s_nxt.dq_out = s_r.out0;
        if (s_r.st0[mhp_pkg::ST_OBF] && !lwr0) begin
          s_nxt.st0[mhp_pkg::ST_OBF] = 1'b0;
          s_nxt.irq[1] = ~s_r.ctl0[mhp_pkg::CTL_OBE_DIS];
        end
      end else begin
        s_nxt.dq_out = s_r.out1;
        if (s_r.st1[mhp_pkg::ST_OBF] && !lwr1) begin
          s_nxt.st1[mhp_pkg::ST_OBF] = 1'b0;
          s_nxt.irq[3] = ~s_r.ctl1[mhp_pkg::CTL_OBE_DIS];
        end
      end
    end
    // Bus driven only while a selected read is active
    // Next enable, so turning the port off drops the drive at once
    s_nxt.dq_oe = rd_act & (sel_a | sel_b)
                  & s_nxt.ctl0[mhp_pkg::CTL_PORT_EN];
    // Write-side A0 captured alongside at the write end
    // A command write is one whose queued A0 level is high
    if (pop) begin
      if (f_out_data[9]) begin
        s_nxt.in1 = f_out_data[7:0];
        s_nxt.st1[mhp_pkg::ST_IBF] = 1'b1;
        s_nxt.st1[mhp_pkg::ST_A0] = f_out_data[8];
        s_nxt.irq[2] = ~s_r.ctl1[mhp_pkg::CTL_IBF_DIS]
                       & (~s_r.ctl1[mhp_pkg::CTL_CMD_ONLY]
                          | f_out_data[8]);
      end else begin
        s_nxt.in0 = f_out_data[7:0];
        s_nxt.st0[mhp_pkg::ST_IBF] = 1'b1;
        s_nxt.st0[mhp_pkg::ST_A0] = f_out_data[8];
        s_nxt.irq[0] = ~s_r.ctl0[mhp_pkg::CTL_IBF_DIS]
                       & (~s_r.ctl0[mhp_pkg::CTL_CMD_ONLY]
                          | f_out_data[8]);
      end
    end
  end

  // Main state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r.ctl0 <= mhp_pkg::REG_RST;
      s_r.ctl1 <= mhp_pkg::REG_RST;
      s_r.st0 <= mhp_pkg::REG_RST;
      s_r.st1 <= mhp_pkg::REG_RST;
      s_r.in0 <= mhp_pkg::REG_RST;
      s_r.in1 <= mhp_pkg::REG_RST;
      s_r.out0 <= mhp_pkg::REG_RST;
      s_r.out1 <= mhp_pkg::REG_RST;
      s_r.dq_out <= 8'h00;
      s_r.dq_oe <= 1'b0;
      s_r.irq <= 4'h0;
    end else begin
      s_r.ctl0 <= s_nxt.ctl0;
      s_r.ctl1 <= s_nxt.ctl1;
      s_r.st0 <= s_nxt.st0;
      s_r.st1 <= s_nxt.st1;
      s_r.in0 <= s_nxt.in0;
      s_r.in1 <= s_nxt.in1;
      s_r.out0 <= s_nxt.out0;
      s_r.out1 <= s_nxt.out1;
      s_r.dq_out <= s_nxt.dq_out;
      s_r.dq_oe <= s_nxt.dq_oe;
      s_r.irq <= s_nxt.irq;
    end
  end

  // Local read mux; unmapped offsets read zero
  always_comb begin
    unique case (sfr_addr)
      mhp_pkg::DATA0_OFS: sfr_rdata = s_r.in0;
      mhp_pkg::STAT0_OFS: sfr_rdata = s_r.st0;
      mhp_pkg::CTRL0_OFS: sfr_rdata = s_r.ctl0;
      mhp_pkg::DATA1_OFS: sfr_rdata = s_r.in1;
      mhp_pkg::STAT1_OFS: sfr_rdata = s_r.st1;
      mhp_pkg::CTRL1_OFS: sfr_rdata = s_r.ctl1;
      default: sfr_rdata = 8'h00;
    endcase
  end

  // Data lines
  assign host_data_lines_out = s_r.dq_out;
  assign host_data_lines_oe = s_r.dq_oe;

  // Flag pins; buffer 1 pins need dual mode
  assign out_buffer_full0 = s_r.st0[mhp_pkg::ST_OBF];
  assign in_buffer_full0_n = ~s_r.st0[mhp_pkg::ST_IBF];
  assign out_buffer_full1 = s_r.st1[mhp_pkg::ST_OBF];
  assign in_buffer_full1_n = ~s_r.st1[mhp_pkg::ST_IBF];
  assign obf0_pin_en = s_r.ctl0[mhp_pkg::CTL_OBF_PIN];
  assign ibf0_pin_en = s_r.ctl0[mhp_pkg::CTL_IBF_PIN];
  assign obf1_pin_en = s_r.ctl1[mhp_pkg::CTL_OBF_PIN] & dual;
  assign ibf1_pin_en = s_r.ctl1[mhp_pkg::CTL_IBF_PIN] & dual;

  // Interrupt pulses
  assign ibf_irq0 = s_r.irq[0];
  assign obe_irq0 = s_r.irq[1];
  assign ibf_irq1 = s_r.irq[2];
  assign obe_irq1 = s_r.irq[3];
endmodule : mhp_host_port

// >>> test/mhp_props.sv
// Checker for the master host port
`timescale 1ns/10ps
module mhp_props (
  // Clock, reset and local bus
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_rdata,
  // Pins and flags
  input wire logic input_threshold_select,
  input wire logic ttl_level_en,
  input wire logic host_data_lines_oe,
  input wire logic host_select_a_n,
  input wire logic host_select_b_n,
  input wire logic port_function_enable,
  input wire logic dual_buffer_select,
  input wire logic out_buffer_full0,
  input wire logic in_buffer_full0_n,
  input wire logic obf1_pin_en,
  input wire logic ibf1_pin_en,
  input wire logic ibf_irq0,
  input wire logic obe_irq0
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ttl_follow_a: assert property (ttl_level_en == input_threshold_select)
    else $error("threshold select not passed on");
  obf_on_load_a: assert property (
    sfr_wr && sfr_addr == mhp_pkg::DATA0_OFS |=> out_buffer_full0)
    else $error("output full not set by load");
  stat_flags_a: assert property (
    sfr_addr == mhp_pkg::STAT0_OFS |-> sfr_rdata[0] == out_buffer_full0
    && sfr_rdata[1] == !in_buffer_full0_n)
    else $error("status flags disagree with pins");
  irq_pulse_a: assert property (ibf_irq0 |=> !ibf_irq0)
    else $error("input interrupt longer than a pulse");
  ibf_irq_full_a: assert property (ibf_irq0 |-> !in_buffer_full0_n)
    else $error("input interrupt without full flag");
  obe_empty_a: assert property (obe_irq0 |-> !out_buffer_full0)
    else $error("empty interrupt with full flag");
  oe_enabled_a: assert property (
    host_data_lines_oe |-> port_function_enable)
    else $error("data lines driven with port off");
  idle_undriven_a: assert property (
    (host_select_a_n && host_select_b_n) [*8] |-> !host_data_lines_oe)
    else $error("data lines driven without select");
  single_pins_a: assert property (
    !dual_buffer_select |-> !obf1_pin_en && !ibf1_pin_en)
    else $error("buffer 1 pins active in single mode");
  // Main scenarios reached
  cover property (ibf_irq0);
  cover property (obe_irq0);
  cover property (host_data_lines_oe && !host_select_a_n);
endmodule : mhp_props
bind mhp_host_port mhp_props i_props (.*);

// >>> test/mhp_master_model.sv
// External master CPU on the parallel host bus
`timescale 1ns/10ps
module mhp_master_model (
  // Clock and strobe style
  input wire logic clk,
  input wire logic rw_style,
  // Resolved data lines
  input wire logic [7:0] bus_in,
  // Pins driven by the master
  output logic sel_a_n,
  output logic sel_b_n,
  output logic a0,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] dq
);
  // Quiet bus at time zero
  initial begin
    sel_a_n = 1'b1;
    sel_b_n = 1'b1;
    a0 = 1'b0;
    dq = 8'h00;
    idle();
  end
  // Strobes off; E is high active in the R/W style
  task automatic idle();
    rd_n = !rw_style;
    wr_n = 1'b1;
  endtask : idle
  // One transfer; strobe held 6 cycles, select and data held 4 more
  task automatic xfer(input logic s, input logic c, input logic r,
                      input logic [7:0] wd, output logic [7:0] rdat);
    @(negedge clk);
    sel_a_n = s;
    sel_b_n = !s;
    a0 = c;
    if (!r)
      dq = wd;
    if (rw_style) begin
      wr_n = r;
      rd_n = 1'b1;
    end else if (r)
      rd_n = 1'b0;
    else
      wr_n = 1'b0;
    repeat (6) @(negedge clk);
    rdat = bus_in;
    idle();
    repeat (4) @(negedge clk);
    sel_a_n = 1'b1;
    sel_b_n = 1'b1;
    dq = ~dq; // Released lines never keep the old byte
    repeat (4) @(negedge clk);
  endtask : xfer
endmodule : mhp_master_model

// >>> test/mhp_host_port_tb_top.sv
// Testbench for the master host port
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module mhp_host_port_tb_top;
  // Clock, reset and local bus
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, tts = 1'b0, rw_style = 1'b0;
  // Master pins and flags
  logic [7:0] dq_out, m_dq, dq_in;
  logic dq_oe, sa_n, sb_n, a0, rd_n, wr_n, ttl, pfe, dbs;
  logic obf0, ibf0_n, ibf1_n, p0o, p0i, p1o, p1i, ffull, ib0, ob0, ib1;
  logic obf1, ob1;
  int errors = 0, checked = 0, cyc = 0, ni0 = 0, no0 = 0, ni1 = 0, no1 = 0;
  logic [7:0] ofs [7] = '{8'h48, 8'h49, 8'h4a, 8'h4c, 8'h4d, 8'h4e, 8'h4b};
  // Shared data wire; the port drives it while dq_oe is high, the master model otherwise
  assign dq_in = dq_oe ? dq_out : m_dq;
  mhp_host_port i_dut (.core_clk(core_clk), .resetn(resetn),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .input_threshold_select(tts), .ttl_level_en(ttl),
    .host_data_lines_in(dq_in), .host_data_lines_out(dq_out),
    .host_data_lines_oe(dq_oe), .host_select_a_n(sa_n),
    .host_select_b_n(sb_n), .cmd_data_select(a0), .host_rd_n(rd_n),
    .host_wr_n(wr_n), .port_function_enable(pfe),
    .dual_buffer_select(dbs), .out_buffer_full0(obf0),
    .in_buffer_full0_n(ibf0_n), .out_buffer_full1(obf1),
    .in_buffer_full1_n(ibf1_n), .obf0_pin_en(p0o), .ibf0_pin_en(p0i),
    .obf1_pin_en(p1o), .ibf1_pin_en(p1i), .ibf_irq0(ib0), .obe_irq0(ob0),
    .ibf_irq1(ib1), .obe_irq1(ob1), .wr_fifo_full(ffull));
  mhp_master_model i_m (.clk(core_clk), .rw_style(rw_style),
    .bus_in(dq_in), .sel_a_n(sa_n), .sel_b_n(sb_n), .a0(a0),
    .rd_n(rd_n), .wr_n(wr_n), .dq(m_dq));
  // 20 MHz clock
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // Pulse counters and hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (ib0 === 1'b1) ni0++;
    if (ob0 === 1'b1) no0++;
    if (ib1 === 1'b1) ni1++;
    if (ob1 === 1'b1) no1++;
    if (cyc == 60000) begin
      errors++;
      conclude();
    end
  end
  // Local register write
  task automatic sw(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask : sw
  // Local register read and compare
  task automatic sr(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge core_clk);
    `CHK(sfr_rdata, e)
    @(negedge core_clk);
    sfr_rd = 1'b0;
  endtask : sr
  // Master write and read through the model
  task automatic mw(input logic s, input logic c, input logic [7:0] v);
    logic [7:0] x;
    i_m.xfer(s, c, 1'b0, v, x);
  endtask : mw
  task automatic mr(input logic s, input logic c, input logic [7:0] e);
    logic [7:0] x;
    i_m.xfer(s, c, 1'b1, 8'h00, x);
    `CHK(x, e)
  endtask : mr
  // Bounded wait for an input full flag
  task automatic wibf(input logic b);
    int n;
    n = 0;
    while ((b ? ibf1_n : ibf0_n) !== 1'b0 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    `CHK(b ? ibf1_n : ibf0_n, 1'b0)
  endtask : wibf
  // Verdict and end of run
  task automatic conclude();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // Test sequence
  initial begin
    repeat (16) @(negedge core_clk);
    resetn = 1'b1;
    repeat (8) @(negedge core_clk);
    foreach (ofs[i]) sr(ofs[i], 8'h00);
    $display("reset values done");
    sw(8'h4a, 8'hff);
    sr(8'h4a, 8'hdf);
    sw(8'h4e, 8'h03);
    `CHK({p1o, p1i}, 2'b00)
    sw(8'h4e, 8'hff);
    sr(8'h4e, 8'h9f);
    `CHK({dbs, p1o}, 2'b11)
    sw(8'h4e, 8'h00);
    sw(8'h4a, 8'h43);
    `CHK({pfe, p0o, p0i}, 3'b111)
    tts = 1'b1;
    @(negedge core_clk);
    `CHK(ttl, 1'b1)
    sw(8'h49, 8'hff);
    sr(8'h49, 8'hf4);
    sw(8'h49, 8'h00);
    $display("control done");
    sw(8'h48, 8'h5a);
    `CHK(obf0, 1'b1)
    mr(1'b0, 1'b1, 8'h01);
    mr(1'b0, 1'b0, 8'h5a);
    `CHK(obf0, 1'b0)
    `CHK(no0, 1)
    mw(1'b0, 1'b0, 8'ha5);
    wibf(1'b0);
    sr(8'h49, 8'h02);
    sr(8'h48, 8'ha5);
    `CHK(ibf0_n, 1'b1)
    mw(1'b0, 1'b1, 8'h3c);
    sr(8'h49, 8'h0a);
    sr(8'h48, 8'h3c);
    `CHK(ni0, 2)
    $display("transfers done");
    sw(8'h4a, 8'h47);
    mw(1'b0, 1'b0, 8'h11);
    sr(8'h48, 8'h11);
    mw(1'b0, 1'b1, 8'h22);
    sr(8'h48, 8'h22);
    `CHK(ni0, 3)
    sw(8'h4a, 8'h5b);
    mw(1'b0, 1'b1, 8'h33);
    sr(8'h48, 8'h33);
    sw(8'h48, 8'h44);
    mr(1'b0, 1'b0, 8'h44);
    `CHK({ni0, no0}, {32'd3, 32'd1})
    sw(8'h4a, 8'hc3);
    rw_style = 1'b1;
    i_m.idle();
    mw(1'b0, 1'b1, 8'h88);
    sr(8'h48, 8'h88);
    sw(8'h48, 8'h99);
    mr(1'b0, 1'b0, 8'h99);
    sw(8'h4a, 8'h43);
    rw_style = 1'b0;
    i_m.idle();
    $display("modes done");
    mw(1'b1, 1'b0, 8'h66);
    `CHK({ibf0_n, ibf1_n}, 2'b11)
    sw(8'h4e, 8'h80);
    mw(1'b1, 1'b0, 8'h77);
    wibf(1'b1);
    sr(8'h4c, 8'h77);
    `CHK(ni1, 1)
    sw(8'h4c, 8'hc5);
    `CHK(obf1, 1'b1)
    mr(1'b1, 1'b1, 8'h01);
    mr(1'b1, 1'b0, 8'hc5);
    `CHK({obf1, no1}, {1'b0, 32'd1})
    for (int i = 0; i < 17; i++) mw(1'b0, 1'b0, 8'(i));
    `CHK(ffull, 1'b1)
    for (int i = 0; i < 17; i++) begin
      wibf(1'b0);
      // Tight drain, at the pace a DMA channel would keep
      sr(8'h48, 8'(i));
    end
    `CHK(ffull, 1'b0)
    $display("buffers done");
    conclude();
  end
endmodule : mhp_host_port_tb_top
